/* rtl/bsx_exec.sv */
// Execution unit for interrupt-flag branches, I/O bit force, shifts, rotates,
// nibble swap, flag force, transfer-flag moves, register moves and X-pointer loads.
// Assumes I/O and data-memory read data are valid in the same cycle as the read strobe.
`timescale 1ns/1ps

module bsx_exec #(
  parameter int unsigned PC_W = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire bsx_pkg::bsx_cmd_t cmd,
  output logic cmd_ready_q,
  output logic done_q,
  output logic [PC_W-1:0] pc_q,
  output logic [bsx_pkg::DATA_W-1:0] status_q,
  output logic io_rd_q,
  output logic io_wr_q,
  output logic [bsx_pkg::IO_AW-1:0] io_addr_q,
  output logic [bsx_pkg::DATA_W-1:0] io_wdata_q,
  input wire logic [bsx_pkg::DATA_W-1:0] io_rdata,
  output logic mem_rd_q,
  output logic [15:0] mem_addr_q,
  input wire logic [bsx_pkg::DATA_W-1:0] mem_rdata,
  input wire logic [bsx_pkg::REG_AW-1:0] peek_addr,
  output logic [bsx_pkg::DATA_W-1:0] peek_data_q
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The branch offset must fit inside the program counter
  if (PC_W < bsx_pkg::BRANCH_W + 1 || PC_W > 22) begin : g_bad_pc
    $error("bsx_exec: PC_W out of range");
  end

  // Register indices must cover the whole register file
  if (bsx_pkg::REG_NUM != (1 << bsx_pkg::REG_AW)) begin : g_bad_regs
    $error("bsx_exec: REG_NUM and REG_AW disagree");
  end

  // Shift and flag logic is written for byte-wide data only
  if (bsx_pkg::DATA_W != 8) begin : g_bad_data
    $error("bsx_exec: DATA_W must be 8");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [bsx_pkg::DATA_W-1:0] regs_q [bsx_pkg::REG_NUM];
  logic [bsx_pkg::DATA_W-1:0] regs_d [bsx_pkg::REG_NUM];
  bsx_pkg::bsx_state_t state_q, state_d;
  bsx_pkg::bsx_cmd_t held_q, held_d;
  logic cmd_ready_d, done_d, io_rd_d, io_wr_d, mem_rd_d;
  logic [PC_W-1:0] pc_d;
  logic [bsx_pkg::DATA_W-1:0] status_d, io_wdata_d, peek_data_d;
  logic [bsx_pkg::IO_AW-1:0] io_addr_d;
  logic [15:0] mem_addr_d;

  // Helpers for shifts, swap, branches and pointer loads
  logic [bsx_pkg::DATA_W-1:0] src, res;
  logic cout;
  logic [15:0] ptr, ptr_new;
  logic [PC_W-1:0] pc_jump;
  logic take;

  // ----------------------------------------
  // Combinational datapath
  // ----------------------------------------
  // Operand fetch and branch target, shared by all commands
  always_comb begin
    src = regs_q[cmd.rd];
    ptr = {regs_q[bsx_pkg::PTR_HI], regs_q[bsx_pkg::PTR_LO]};
    pc_jump = pc_q + PC_W'(cmd.k) + PC_W'(1); // Sign-extended offset
    take = 1'b0;
    if (cmd.op == bsx_pkg::OP_BR_IE) begin
      take = status_q[bsx_pkg::FLAG_I];
    end else if (cmd.op == bsx_pkg::OP_BR_ID) begin
      take = ~status_q[bsx_pkg::FLAG_I];
    end
  end

  // Shift and rotate result plus outgoing carry
  always_comb begin
    res = src;
    cout = status_q[bsx_pkg::FLAG_C];
    case (cmd.op)
      bsx_pkg::OP_LOGICAL_LEFT_SHIFT: begin
        res = {src[6:0], 1'b0};
        cout = src[7];
      end
      bsx_pkg::OP_LOGICAL_RIGHT_SHIFT: begin
        res = {1'b0, src[7:1]};
        cout = src[0];
      end
      bsx_pkg::OP_ROTATE_LEFT_CARRY: begin
        res = {src[6:0], status_q[bsx_pkg::FLAG_C]};
        cout = src[7];
      end
      bsx_pkg::OP_ROTATE_RIGHT_CARRY: begin
        res = {status_q[bsx_pkg::FLAG_C], src[7:1]};
        cout = src[0];
      end
      bsx_pkg::OP_ARITH_RIGHT_SHIFT: begin
        res = {src[7], src[7:1]};
        cout = src[0];
      end
      default: begin
        res = src;
        cout = status_q[bsx_pkg::FLAG_C];
      end
    endcase
  end

  // Next-state logic for the whole unit
  always_comb begin
    regs_d = regs_q;
    state_d = state_q;
    held_d = held_q;
    cmd_ready_d = cmd_ready_q;
    done_d = 1'b0;
    io_rd_d = 1'b0;
    io_wr_d = 1'b0;
    io_addr_d = io_addr_q;
    io_wdata_d = io_wdata_q;
    mem_rd_d = 1'b0;
    mem_addr_d = mem_addr_q;
    pc_d = pc_q;
    status_d = status_q;
    ptr_new = ptr;
    peek_data_d = regs_q[peek_addr];
    case (state_q)
      bsx_pkg::ST_IDLE: begin
        // Offers made while busy are ignored, never queued
        if (cmd_valid && cmd_ready_q) begin
          held_d = cmd;
          pc_d = pc_q + PC_W'(1);
          done_d = 1'b1;
          case (cmd.op)
            bsx_pkg::OP_BR_IE, bsx_pkg::OP_BR_ID: begin
              // Taken branch costs a second cycle
              if (take) begin
                pc_d = pc_jump;
                done_d = 1'b0;
                cmd_ready_d = 1'b0;
                state_d = bsx_pkg::ST_BR_WAIT;
              end
            end
            bsx_pkg::OP_IO_SET, bsx_pkg::OP_IO_CLR: begin
              // Read first, modify and write in the second cycle
              io_rd_d = 1'b1;
              io_addr_d = cmd.io_addr;
              done_d = 1'b0;
              cmd_ready_d = 1'b0;
              state_d = bsx_pkg::ST_IO_WAIT;
            end
            bsx_pkg::OP_LOGICAL_LEFT_SHIFT, bsx_pkg::OP_LOGICAL_RIGHT_SHIFT, bsx_pkg::OP_ROTATE_LEFT_CARRY,
            bsx_pkg::OP_ROTATE_RIGHT_CARRY, bsx_pkg::OP_ARITH_RIGHT_SHIFT: begin
              regs_d[cmd.rd] = res;
              status_d[bsx_pkg::FLAG_C] = cout;
              status_d[bsx_pkg::FLAG_Z] = (res == 8'h00);
              status_d[bsx_pkg::FLAG_N] = res[7];
              status_d[bsx_pkg::FLAG_V] = res[7] ^ cout; // Sign flag left alone
            end
            bsx_pkg::OP_SWAP: begin
              regs_d[cmd.rd] = {src[3:0], src[7:4]};
            end
            bsx_pkg::OP_FLAG_SET: begin
              status_d[cmd.bsel] = 1'b1;
            end
            bsx_pkg::OP_FLAG_CLR: begin
              status_d[cmd.bsel] = 1'b0;
            end
            bsx_pkg::OP_BIT_TO_T: begin
              status_d[bsx_pkg::FLAG_T] = regs_q[cmd.rr][cmd.bsel];
            end
            bsx_pkg::OP_T_TO_BIT: begin
              regs_d[cmd.rd][cmd.bsel] = status_q[bsx_pkg::FLAG_T];
            end
            bsx_pkg::OP_MOV: begin
              regs_d[cmd.rd] = regs_q[cmd.rr];
            end
            bsx_pkg::OP_PAIR_COPY: begin
              // Pair registers are even-aligned; low index bit ignored
              regs_d[{cmd.rd[4:1], 1'b0}] = regs_q[{cmd.rr[4:1], 1'b0}];
              regs_d[{cmd.rd[4:1], 1'b1}] = regs_q[{cmd.rr[4:1], 1'b1}];
            end
            bsx_pkg::OP_LOAD_IMM: begin
              regs_d[cmd.rd] = cmd.imm;
            end
            bsx_pkg::OP_LD_X, bsx_pkg::OP_LD_X_INC, bsx_pkg::OP_LD_X_DEC: begin
              mem_rd_d = 1'b1;
              mem_addr_d = ptr;
              if (cmd.op == bsx_pkg::OP_LD_X_DEC) begin
                mem_addr_d = ptr - bsx_pkg::PTR_STEP; // Address after decrement
              end
              done_d = 1'b0;
              cmd_ready_d = 1'b0;
              state_d = bsx_pkg::ST_LD_WAIT;
            end
            default: begin
              done_d = 1'b1;
            end
          endcase
        end
      end
      bsx_pkg::ST_IO_WAIT: begin
        // Read data is valid now; write back the one modified bit
        // No wait states: a slow I/O location must answer within this cycle
        io_wr_d = 1'b1;
        io_wdata_d = io_rdata;
        if (held_q.op == bsx_pkg::OP_IO_SET) begin
          io_wdata_d[held_q.bsel] = 1'b1;
        end else begin
          io_wdata_d[held_q.bsel] = 1'b0;
        end
        done_d = 1'b1;
        cmd_ready_d = 1'b1;
        state_d = bsx_pkg::ST_IDLE;
      end
      bsx_pkg::ST_LD_WAIT: begin
        // Memory read data must also be valid in this very cycle
        if (held_q.op == bsx_pkg::OP_LD_X_INC) begin
          ptr_new = ptr + bsx_pkg::PTR_STEP;
        end else if (held_q.op == bsx_pkg::OP_LD_X_DEC) begin
          ptr_new = mem_addr_q;
        end
        regs_d[bsx_pkg::PTR_LO] = ptr_new[7:0];
        regs_d[bsx_pkg::PTR_HI] = ptr_new[15:8];
        // Loaded data wins when the target is a pointer byte
        regs_d[held_q.rd] = mem_rdata;
        done_d = 1'b1;
        cmd_ready_d = 1'b1;
        state_d = bsx_pkg::ST_IDLE;
      end
      bsx_pkg::ST_BR_WAIT: begin
        done_d = 1'b1;
        cmd_ready_d = 1'b1;
        state_d = bsx_pkg::ST_IDLE;
      end
      default: begin
        cmd_ready_d = 1'b1;
        state_d = bsx_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Synchronous reset; register file clears too so tests start clean
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < bsx_pkg::REG_NUM; i++) begin
        regs_q[i] <= bsx_pkg::REG_RESET;
      end
      state_q <= bsx_pkg::ST_IDLE;
      held_q <= '0;
      cmd_ready_q <= 1'b1;
      done_q <= 1'b0;
      io_rd_q <= 1'b0;
      io_wr_q <= 1'b0;
      io_addr_q <= '0;
      io_wdata_q <= '0;
      mem_rd_q <= 1'b0;
      mem_addr_q <= '0;
      pc_q <= '0;
      status_q <= bsx_pkg::STATUS_RESET;
      peek_data_q <= '0;
    end else begin
      regs_q <= regs_d;
      state_q <= state_d;
      held_q <= held_d;
      cmd_ready_q <= cmd_ready_d;
      done_q <= done_d;
      io_rd_q <= io_rd_d;
      io_wr_q <= io_wr_d;
      io_addr_q <= io_addr_d;
      io_wdata_q <= io_wdata_d;
      mem_rd_q <= mem_rd_d;
      mem_addr_q <= mem_addr_d;
      pc_q <= pc_d;
      status_q <= status_d;
      peek_data_q <= peek_data_d;
    end
  end

endmodule

/* rtl/bsx_pkg.sv */
// Package for the bit, shift, flag and move execution unit.
// Assumes one 10 MHz clock domain and a core sequencer that issues one command at a time.
package bsx_pkg;

  // ----------------------------------------
  // Status flag positions
  // ----------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned FLAG_I = 7;

  // ----------------------------------------
  // Widths, indices and reset values
  // ----------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_NUM = 32;
  localparam int unsigned REG_AW = 5;
  localparam int unsigned IO_AW = 5;
  localparam int unsigned BRANCH_W = 7;
  localparam logic [REG_AW-1:0] PTR_LO = 5'h1a;
  localparam logic [REG_AW-1:0] PTR_HI = 5'h1b;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  // ----------------------------------------
  // Commands and sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_BR_IE, OP_BR_ID, OP_IO_SET, OP_IO_CLR,
    OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_RIGHT_SHIFT, OP_SWAP,
    OP_FLAG_SET, OP_FLAG_CLR, OP_BIT_TO_T, OP_T_TO_BIT,
    OP_MOV, OP_PAIR_COPY, OP_LOAD_IMM, OP_LD_X, OP_LD_X_INC, OP_LD_X_DEC
  } bsx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE, ST_IO_WAIT, ST_LD_WAIT, ST_BR_WAIT
  } bsx_state_t;

  // One issued command
  typedef struct packed {
    bsx_op_t op;
    logic [REG_AW-1:0] rd;
    logic [REG_AW-1:0] rr;
    logic [2:0] bsel;
    logic [IO_AW-1:0] io_addr;
    logic signed [BRANCH_W-1:0] k;
    logic [DATA_W-1:0] imm;
  } bsx_cmd_t;

endpackage

/* dv/bsx_exec_monitor.sv */
// Checker for the bit, shift, flag and move execution unit.
// Assumes it is bound to bsx_exec and sees only the unit's ports.
`timescale 1ns/1ps
module bsx_exec_monitor #(
  parameter int unsigned PC_W = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire bsx_pkg::bsx_cmd_t cmd,
  input wire logic cmd_ready_q,
  input wire logic done_q,
  input wire logic [PC_W-1:0] pc_q,
  input wire logic [bsx_pkg::DATA_W-1:0] status_q,
  input wire logic io_rd_q,
  input wire logic io_wr_q,
  input wire logic [bsx_pkg::DATA_W-1:0] io_wdata_q,
  input wire logic [bsx_pkg::DATA_W-1:0] io_rdata,
  input wire logic mem_rd_q
);
  // ----
  // Helpers
  // ----
  logic take;
  logic is_br;
  logic br_go;
  logic [PC_W-1:0] k_ext;
  // Decoded view of the command taken this cycle
  assign take = cmd_valid && cmd_ready_q;
  assign is_br = take && (cmd.op == bsx_pkg::OP_BR_IE || cmd.op == bsx_pkg::OP_BR_ID);
  assign br_go = (cmd.op == bsx_pkg::OP_BR_IE) ? status_q[bsx_pkg::FLAG_I] : !status_q[bsx_pkg::FLAG_I];
  assign k_ext = {{(PC_W-7){cmd.k[6]}}, cmd.k};  // Offset is signed

  // ----
  // Properties
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  br_taken_a: assert property (is_br && br_go |=>
    !cmd_ready_q && !done_q && pc_q == PC_W'($past(pc_q) + $past(k_ext) + 1) ##1 done_q)
    else $error("taken branch wrong target or timing");
  br_skip_a: assert property (is_br && !br_go |=> done_q && pc_q == PC_W'($past(pc_q) + 1))
    else $error("untaken branch wrong");
  io_set_a: assert property (take && cmd.op == bsx_pkg::OP_IO_SET |=> io_rd_q && !cmd_ready_q ##1
    io_wr_q && done_q && io_wdata_q == ($past(io_rdata) | (8'h01 << $past(cmd.bsel, 2))))
    else $error("io bit set wrong");
  io_clr_a: assert property (take && cmd.op == bsx_pkg::OP_IO_CLR |=> io_rd_q && !cmd_ready_q ##1
    io_wr_q && done_q && io_wdata_q == ($past(io_rdata) & ~(8'h01 << $past(cmd.bsel, 2))))
    else $error("io bit clear wrong");
  flag_set_a: assert property (take && cmd.op == bsx_pkg::OP_FLAG_SET |=>
    done_q && status_q == ($past(status_q) | (8'h01 << $past(cmd.bsel))))
    else $error("flag set wrong");
  flag_clr_a: assert property (take && cmd.op == bsx_pkg::OP_FLAG_CLR |=>
    done_q && status_q == ($past(status_q) & ~(8'h01 << $past(cmd.bsel))))
    else $error("flag clear wrong");
  shift_flags_a: assert property (take &&
    cmd.op inside {[bsx_pkg::OP_LOGICAL_LEFT_SHIFT:bsx_pkg::OP_ARITH_RIGHT_SHIFT]} |=>
    done_q && status_q[3] == (status_q[2] ^ status_q[0]) && (status_q & 8'hf0) == ($past(status_q) & 8'hf0))
    else $error("shift flags wrong");
  flags_kept_a: assert property (take && cmd.op inside {bsx_pkg::OP_SWAP, bsx_pkg::OP_T_TO_BIT,
    bsx_pkg::OP_MOV, bsx_pkg::OP_PAIR_COPY} |=> done_q && $stable(status_q))
    else $error("flags changed by move");
  load_wait_a: assert property (take &&
    cmd.op inside {bsx_pkg::OP_LD_X, bsx_pkg::OP_LD_X_INC, bsx_pkg::OP_LD_X_DEC} |=>
    mem_rd_q && !done_q ##1 done_q && cmd_ready_q && status_q == $past(status_q, 2))
    else $error("pointer load timing wrong");
  t_only_a: assert property (take && cmd.op == bsx_pkg::OP_BIT_TO_T |=>
    ((status_q ^ $past(status_q)) & 8'hbf) == 8'h00)
    else $error("bit store touched other flags");
endmodule

bind bsx_exec bsx_exec_monitor #(.PC_W(PC_W)) i_bsx_exec_monitor (.mclk, .sys_rst, .cmd_valid, .cmd,
  .cmd_ready_q, .done_q, .pc_q, .status_q, .io_rd_q, .io_wr_q, .io_wdata_q, .io_rdata, .mem_rd_q);

/* dv/tb.sv */
// Self-checking bench for the bit, shift, flag and move execution unit.
// Assumes the checker is bound in; the bench plays sequencer, I/O space and data memory.
`timescale 1ns/1ps
module tb;
  // ----
  // Signals and state
  // ----
  typedef struct packed {
    bsx_pkg::bsx_op_t op; logic [2:0] b; logic [7:0] val; logic [7:0] res; logic [3:0] fl;
  } bsx_row_t;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  bsx_pkg::bsx_cmd_t cmd = '0;
  logic cmd_ready_q, done_q, io_rd_q, io_wr_q, mem_rd_q;
  logic [4:0] io_addr_q, raddr;
  logic [4:0] peek_addr = 5'h00;
  logic [7:0] status_q, io_wdata_q, peek_data_q, wdat, r_e;
  logic [7:0] io_rdata = 8'h00;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] s_e = 8'h00;
  logic [15:0] pc_q, mem_addr_q, maddr;
  logic [15:0] pc_e = 16'h0000;
  int bad_count = 0;
  int num_checks = 0;
  int lat;
  // Awkward carries: zero result, carry in and out, sign kept
  // Columns: op, bit, operand, expected result, expected flags V N Z C
  bsx_row_t rows [7] = '{'{bsx_pkg::OP_LOGICAL_LEFT_SHIFT, 3'h0, 8'h81, 8'h02, 4'h9},
    '{bsx_pkg::OP_LOGICAL_RIGHT_SHIFT, 3'h0, 8'h01, 8'h00, 4'hb},
    '{bsx_pkg::OP_ROTATE_LEFT_CARRY, 3'h0, 8'h80, 8'h01, 4'h9},
    '{bsx_pkg::OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h02, 8'h81, 4'hc},
    '{bsx_pkg::OP_ARITH_RIGHT_SHIFT, 3'h0, 8'h81, 8'hc0, 4'h5},
    '{bsx_pkg::OP_SWAP, 3'h0, 8'h3c, 8'hc3, 4'h5}, '{bsx_pkg::OP_BIT_TO_T, 3'h3, 8'h08, 8'h08, 4'h5}};

  bsx_exec #(.PC_W(16)) i_bsx_exec (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready_q(cmd_ready_q), .done_q(done_q), .pc_q(pc_q), .status_q(status_q), .io_rd_q(io_rd_q),
    .io_wr_q(io_wr_q), .io_addr_q(io_addr_q), .io_wdata_q(io_wdata_q), .io_rdata(io_rdata),
    .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata), .peek_addr(peek_addr),
    .peek_data_q(peek_data_q));

  // 100 ns clock
  initial begin
    forever #50 mclk = ~mclk;
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One command; im doubles as branch offset, so the bench knows the pc step
  task automatic run(input bsx_pkg::bsx_op_t op, input logic [4:0] rd, input logic [4:0] rr,
      input logic [2:0] b, input logic [7:0] im);
    logic tk;
    logic two;
    tk = (op == bsx_pkg::OP_BR_IE) ? s_e[7] : (op == bsx_pkg::OP_BR_ID) ? !s_e[7] : 1'b0;
    two = tk || op inside {bsx_pkg::OP_IO_SET, bsx_pkg::OP_IO_CLR, bsx_pkg::OP_LD_X,
      bsx_pkg::OP_LD_X_INC, bsx_pkg::OP_LD_X_DEC};
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, rd: rd, rr: rr, bsel: b, io_addr: rd, k: im[6:0], imm: im};
    @(posedge mclk);
    cmd_valid <= 1'b0;
    lat = 0;
    do begin
      #1;
      lat++;
      if (io_rd_q === 1'b1) raddr = io_addr_q;
      if (io_wr_q === 1'b1) wdat = io_wdata_q;
      if (mem_rd_q === 1'b1) maddr = mem_addr_q;
      if (lat > 4) begin
        bad_count++;
        $display("Error at %0t: command timed out", $time);
        end_sim;
      end
      if (done_q !== 1'b1) @(posedge mclk);
    end while (done_q !== 1'b1);
    pc_e = pc_e + (tk ? {{9{im[6]}}, im[6:0]} + 16'h0001 : 16'h0001);
    chk(pc_q, pc_e);
    chk(16'(lat), two ? 16'h0002 : 16'h0001);
  endtask

  // Register value one cycle after the address is offered
  task automatic peek(input logic [4:0] r, input logic [7:0] exp);
    @(posedge mclk);
    peek_addr <= r;
    @(posedge mclk);
    #1;
    chk(peek_data_q, exp);
  endtask

  // Preload r3, apply one op to it, compare result and flags with the model
  task automatic do_row(input bsx_pkg::bsx_op_t op, input logic [2:0] b, input logic [7:0] x);
    logic c;
    run(bsx_pkg::OP_LOAD_IMM, 5'h03, 5'h03, 3'h0, x);
    run(op, 5'h03, 5'h03, b, 8'h00);
    c = s_e[0];
    r_e = x;
    case (op)
      bsx_pkg::OP_LOGICAL_LEFT_SHIFT: {c, r_e} = {x, 1'b0};
      bsx_pkg::OP_LOGICAL_RIGHT_SHIFT: {r_e, c} = {1'b0, x};
      bsx_pkg::OP_ROTATE_LEFT_CARRY: {c, r_e} = {x, s_e[0]};
      bsx_pkg::OP_ROTATE_RIGHT_CARRY: {r_e, c} = {s_e[0], x};
      bsx_pkg::OP_ARITH_RIGHT_SHIFT: {r_e, c} = {x[7], x};
      bsx_pkg::OP_SWAP: r_e = {x[3:0], x[7:4]};
      bsx_pkg::OP_FLAG_SET: s_e[b] = 1'b1;
      bsx_pkg::OP_FLAG_CLR: s_e[b] = 1'b0;
      bsx_pkg::OP_BIT_TO_T: s_e[6] = x[b];
      bsx_pkg::OP_T_TO_BIT: r_e[b] = s_e[6];
      default: ;
    endcase
    if (op inside {[bsx_pkg::OP_LOGICAL_LEFT_SHIFT:bsx_pkg::OP_ARITH_RIGHT_SHIFT]}) begin
      s_e[3:0] = {r_e[7] ^ c, r_e[7], r_e == 8'h00, c};
    end
    chk(status_q, s_e);
    peek(5'h03, r_e);
    $display("test %s done", op.name());
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk(pc_q, 16'h0000);
    chk(status_q, 8'h00);
    chk(cmd_ready_q, 1'b1);
    $display("test reset done");
    foreach (rows[i]) begin
      do_row(rows[i].op, rows[i].b, rows[i].val);
      chk(status_q[3:0], rows[i].fl);
      peek(5'h03, rows[i].res);
    end
    do_row(bsx_pkg::OP_T_TO_BIT, 3'h0, 8'h00);
    do_row(bsx_pkg::OP_BIT_TO_T, 3'h0, 8'hfe);
    do_row(bsx_pkg::OP_T_TO_BIT, 3'h7, 8'hff);
    for (int i = 0; i < 16; i++) do_row(i[0] ? bsx_pkg::OP_FLAG_CLR : bsx_pkg::OP_FLAG_SET, i[3:1], 8'h00);
    // Both branches with the interrupt flag clear, then set; offsets -3 and +5
    run(bsx_pkg::OP_BR_IE, 5'h00, 5'h00, 3'h0, 8'h7d);
    run(bsx_pkg::OP_BR_ID, 5'h00, 5'h00, 3'h0, 8'h7d);
    do_row(bsx_pkg::OP_FLAG_SET, 3'h7, 8'h00);
    run(bsx_pkg::OP_BR_IE, 5'h00, 5'h00, 3'h0, 8'h05);
    run(bsx_pkg::OP_BR_ID, 5'h00, 5'h00, 3'h0, 8'h05);
    $display("test branch done");
    // Read-modify-write of one I/O byte
    @(posedge mclk);
    io_rdata <= 8'h81;
    run(bsx_pkg::OP_IO_SET, 5'h09, 5'h00, 3'h2, 8'h00);
    chk(wdat, 8'h85);
    chk(raddr, 5'h09);
    run(bsx_pkg::OP_IO_CLR, 5'h1f, 5'h00, 3'h7, 8'h00);
    chk(wdat, 8'h01);
    chk(status_q, s_e);
    $display("test io done");
    // Pointer loads at 0x0210, then moves
    run(bsx_pkg::OP_LOAD_IMM, 5'h1a, 5'h00, 3'h0, 8'h10);
    run(bsx_pkg::OP_LOAD_IMM, 5'h1b, 5'h00, 3'h0, 8'h02);
    @(posedge mclk);
    mem_rdata <= 8'h5a;
    run(bsx_pkg::OP_LD_X_INC, 5'h05, 5'h00, 3'h0, 8'h00);
    chk(maddr, 16'h0210);
    peek(5'h1a, 8'h11);
    @(posedge mclk);
    mem_rdata <= 8'ha5;
    run(bsx_pkg::OP_LD_X_DEC, 5'h06, 5'h00, 3'h0, 8'h00);
    chk(maddr, 16'h0210);
    peek(5'h1a, 8'h10);
    peek(5'h06, 8'ha5);
    run(bsx_pkg::OP_MOV, 5'h07, 5'h05, 3'h0, 8'h00);
    peek(5'h07, 8'h5a);
    run(bsx_pkg::OP_PAIR_COPY, 5'h09, 5'h1b, 3'h0, 8'h00);
    peek(5'h08, 8'h10);
    peek(5'h09, 8'h02);
    chk(status_q, s_e);
    $display("test load and move done");
    // Second reset in mid-run
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk(pc_q, 16'h0000);
    chk(status_q, 8'h00);
    chk(cmd_ready_q, 1'b1);
    // Plain load after reset: X is zero again and must stay so
    pc_e = 16'h0000;
    s_e = 8'h00;
    run(bsx_pkg::OP_NOP, 5'h00, 5'h00, 3'h0, 8'h00);
    run(bsx_pkg::OP_LD_X, 5'h04, 5'h00, 3'h0, 8'h00);
    chk(maddr, 16'h0000);
    peek(5'h04, 8'ha5);
    peek(5'h1a, 8'h00);
    peek(5'h07, 8'h00);
    $display("test second reset done");
    end_sim;
  end
endmodule
